/* src/aio_image_params.svh */
// Constants for the analog I/O input image: word indexes, field positions,
// reset values. Included by the package and by the design module.
`ifndef AIO_IMAGE_PARAMS_SVH
`define AIO_IMAGE_PARAMS_SVH
// Input image words, read only
`define IDX_IN0          4'h0
`define IDX_IN1          4'h1
`define IDX_IN2          4'h2
`define IDX_IN3          4'h3
`define IDX_IN_OVER      4'h4
`define IDX_OUT_STATUS   4'h5
`define IDX_ECHO0        4'h6
`define IDX_ECHO1        4'h7
// Controller side words
`define IDX_OUT_WORD0    4'h8
`define IDX_OUT_WORD1    4'h9
`define IDX_MODE_CTRL    4'hA
`define IDX_EVT_STATUS   4'hB
`define IDX_EVT_MASK     4'hC
// Value field of a 16-bit word
`define VAL_LSB          7
`define VAL_MSB          14
`define SIGN_BIT         15
`define FULL_CODE        8'hFF
// Output status word fields
`define BAD0_BIT         2
`define BAD1_BIT         3
`define HOLD1_BIT        12
`define HOLD0_BIT        14
// Mode control fields
`define MODE_RUN_BIT     0
`define MODE_SEL0_BIT    1
`define MODE_SEL1_BIT    2
// Event status fields
`define EVT_IN_OVER_BIT  0
`define EVT_OUT_OVER_BIT 1
`define EVT_BAD_BIT      2
// Reset values
`define WORD_RESET       16'h0000
`define CODE_RESET       8'h00
`define EVT_RESET        3'h0
`endif

/* src/aio_image_pkg.sv */
// Types shared by the analog I/O input image block.
// Assumes aio_image_params.svh is on the include path.
package aio_image_pkg;
  `include "aio_image_params.svh"

  typedef logic [15:0] word_t;
  typedef logic [7:0]  code_t;

  // One converter update: four input codes and range flags
  typedef struct packed {
    logic             valid;
    logic [3:0][7:0]  code;
    logic [3:0]       over;
    logic [1:0]       out_over;
  } conv_in_s;

  // Register port request from the controller
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // Idle behaviour of an output channel in program mode
  typedef enum logic {
    IDLE_HOLD,
    IDLE_ZERO
  } idle_sel_e;
endpackage : aio_image_pkg

/* src/analog_io_input_image.sv */
// Input image of an analog I/O module: four input words, two status words
// and two output echo words, plus the output words written by the host.
// Assumes converter results arrive from logic on clk, one valid pulse per
// update, and the host register port is synchronous to clk.
// Output words, mode control and events sit above the image in the word map.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Field and index constants; the guard makes a second include harmless
`include "aio_image_params.svh"

module analog_io_input_image (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire aio_image_pkg::conv_in_s conv,
  input  wire aio_image_pkg::reg_req_s req,
  output logic [15:0]                  rd_data,
  output logic [7:0]                   dac_code0,
  output logic [7:0]                   dac_code1,
  output logic                         irq
);
  import aio_image_pkg::*;

  // Image storage, flip-flops indexed by word number
  word_t      image [0:7];
  code_t      accepted [0:1];
  code_t      drive [0:1];
  logic [1:0] bad_flag;
  logic [2:0] mode_ctrl;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [2:0] next_evt;
  logic       wr_bad0;
  logic       wr_bad1;
  logic       program_mode;
  logic [1:0] holding;
  logic       seen_update;

  // Left-justified word with sign forced low
  function automatic word_t pack_code(input code_t c);
    pack_code = {1'b0, c, 7'h00};
  endfunction : pack_code

  // Output word check; range and step reduce to these bits
  function automatic logic word_bad(input word_t w);
    word_bad = (|w[`VAL_LSB-1:0]) | w[`SIGN_BIT];
  endfunction : word_bad

  function automatic code_t clamp(input code_t c, input logic ov);
    clamp = ov ? `FULL_CODE : c;
  endfunction : clamp

  // Image slot of a word index; only the low three bits pick a slot
  function automatic logic [2:0] word_slot(input logic [3:0] idx);
    word_slot = idx[2:0];
  endfunction : word_slot

  assign wr_bad0      = req.wr && req.addr == `IDX_OUT_WORD0 && word_bad(req.wdata);
  assign wr_bad1      = req.wr && req.addr == `IDX_OUT_WORD1 && word_bad(req.wdata);
  assign program_mode = !mode_ctrl[`MODE_RUN_BIT];
  // Holding only when program mode and hold chosen
  assign holding[0]   = program_mode && mode_ctrl[`MODE_SEL0_BIT] == IDLE_HOLD;
  assign holding[1]   = program_mode && mode_ctrl[`MODE_SEL1_BIT] == IDLE_HOLD;

  // Accepted output codes; a bad write leaves the old value standing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accepted[0] <= `CODE_RESET;
      accepted[1] <= `CODE_RESET;
    end else if (req.wr) begin
      if (req.addr == `IDX_OUT_WORD0 && !wr_bad0) begin
        accepted[0] <= req.wdata[`VAL_MSB:`VAL_LSB];
      end
      if (req.addr == `IDX_OUT_WORD1 && !wr_bad1) begin
        accepted[1] <= req.wdata[`VAL_MSB:`VAL_LSB];
      end
    end
  end

  // Invalid-data flags: set by a bad write, cleared by the next good one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bad_flag <= 2'h0;
    end else if (req.wr) begin
      if (req.addr == `IDX_OUT_WORD0) begin
        bad_flag[0] <= wr_bad0;
      end
      if (req.addr == `IDX_OUT_WORD1) begin
        bad_flag[1] <= wr_bad1;
      end
    end
  end

  // Run/program and idle selection, written by the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ctrl <= 3'h0;
    end else if (req.wr && req.addr == `IDX_MODE_CTRL) begin
      mode_ctrl <= req.wdata[2:0];
    end
  end

  // Code fed to the converters; frozen while holding, zero when idled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive[0] <= `CODE_RESET;
      drive[1] <= `CODE_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!program_mode) begin
          drive[i] <= clamp(accepted[i], conv.out_over[i]);
        end else if (!holding[i]) begin
          drive[i] <= `CODE_RESET;
        end
      end
    end
  end
  assign dac_code0 = drive[0];
  assign dac_code1 = drive[1];

  // Image refresh on every converter update; host writes never land here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        image[i] <= `WORD_RESET;
      end
    end else if (conv.valid) begin
      for (int i = 0; i < 4; i++) begin
        image[i] <= pack_code(clamp(conv.code[i], conv.over[i]));
      end
      // Status words are snapshots; they never move between updates
      image[word_slot(`IDX_IN_OVER)] <= {12'h000, conv.over};
      image[word_slot(`IDX_OUT_STATUS)] <= {1'b0, holding[0], 1'b0, holding[1], 8'h00,
                                            bad_flag, conv.out_over};
      image[word_slot(`IDX_ECHO0)] <= pack_code(drive[0]);
      image[word_slot(`IDX_ECHO1)] <= pack_code(drive[1]);
    end
  end

  // Events: sticky, write one to clear, set wins over clear
  always_comb begin
    next_evt = evt_status;
    if (req.wr && req.addr == `IDX_EVT_STATUS) begin
      next_evt = evt_status & ~req.wdata[2:0];
    end
    next_evt[`EVT_IN_OVER_BIT]  |= conv.valid && (|conv.over);
    next_evt[`EVT_OUT_OVER_BIT] |= conv.valid && (|conv.out_over);
    next_evt[`EVT_BAD_BIT]      |= wr_bad0 | wr_bad1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status <= `EVT_RESET;
    end else begin
      evt_status <= next_evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask <= `EVT_RESET;
    end else if (req.wr && req.addr == `IDX_EVT_MASK) begin
      evt_mask <= req.wdata[2:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

  // Read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= `WORD_RESET;
    end else if (req.rd) begin
      case (req.addr)
        `IDX_IN0, `IDX_IN1, `IDX_IN2, `IDX_IN3, `IDX_IN_OVER,
        `IDX_OUT_STATUS, `IDX_ECHO0, `IDX_ECHO1: rd_data <= image[req.addr[2:0]];
        `IDX_OUT_WORD0: rd_data <= pack_code(accepted[0]);
        `IDX_OUT_WORD1: rd_data <= pack_code(accepted[1]);
        `IDX_MODE_CTRL: rd_data <= {13'h0000, mode_ctrl};
        `IDX_EVT_STATUS: rd_data <= {13'h0000, evt_status};
        `IDX_EVT_MASK: rd_data <= {13'h0000, evt_mask};
        default: rd_data <= `WORD_RESET;
      endcase
    end else begin
      rd_data <= `WORD_RESET;
    end
  end

  // Check helper: set by the first converter update after reset.
  // Lets the reset check run without counting cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_update <= 1'b0;
    end else if (conv.valid) begin
      seen_update <= 1'b1;
    end
  end

  // Checks on the image and output paths
  sequence upd_over0_s;
    conv.valid && conv.over[0];
  endsequence

  sequence bad_write0_s;
    wr_bad0;
  endsequence

  sequence upd_clean0_s;
    conv.valid && !conv.over[0];
  endsequence

  sequence good_write0_s;
    req.wr && req.addr == `IDX_OUT_WORD0 && !wr_bad0;
  endsequence

  sequence good_write1_s;
    req.wr && req.addr == `IDX_OUT_WORD1 && !wr_bad1;
  endsequence

  sequence in_over_evt_s;
    conv.valid && (|conv.over);
  endsequence

  sequence evt_clear0_s;
    req.wr && req.addr == `IDX_EVT_STATUS && req.wdata[`EVT_IN_OVER_BIT]
    && !(conv.valid && (|conv.over));
  endsequence

  low_bits_zero_a: assert property (@(posedge clk) disable iff (rst)
    image[0][6:0] == 7'h00 && image[3][6:0] == 7'h00)
    else $error("input word low bits not zero");

  sign_zero_a: assert property (@(posedge clk) disable iff (rst)
    !image[1][`SIGN_BIT] && !image[2][`SIGN_BIT])
    else $error("input sign bit set");

  code_place_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && !conv.over[2] |=> image[2][14:7] == $past(conv.code[2]))
    else $error("input code misplaced");

  over_clamp_a: assert property (@(posedge clk) disable iff (rst)
    upd_over0_s |=> image[0] == 16'h7F80 && image[word_slot(`IDX_IN_OVER)][0])
    else $error("over-range not clamped or flagged");

  flag_clears_a: assert property (@(posedge clk) disable iff (rst)
    upd_over0_s ##[1:64] upd_clean0_s |=> !image[word_slot(`IDX_IN_OVER)][0])
    else $error("over-range flag stuck");

  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    image[word_slot(`IDX_IN_OVER)][15:4] == 12'h000
    && image[word_slot(`IDX_OUT_STATUS)][11:4] == 8'h00
    && !image[word_slot(`IDX_OUT_STATUS)][15] && !image[word_slot(`IDX_OUT_STATUS)][13])
    else $error("unused image bit set");

  bad_keep_a: assert property (@(posedge clk) disable iff (rst)
    bad_write0_s |=> accepted[0] == $past(accepted[0]) && bad_flag[0])
    else $error("bad output word accepted");

  hold_flag_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && holding[0] |=> image[word_slot(`IDX_OUT_STATUS)][`HOLD0_BIT]
    && dac_code0 == $past(dac_code0))
    else $error("hold not shown or not held");

  echo_match_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_ECHO1)][14:7] == $past(dac_code1))
    else $error("echo differs from converted code");

  read_once_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == `IDX_IN0 && !conv.valid |=> rd_data == image[0])
    else $error("read data wrong");

  // Stale data would look like a second answer to the host
  read_idle_a: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> rd_data == 16'h0000)
    else $error("read data stands too long");

  // Input words
  low_bits_rest_a: assert property (@(posedge clk) disable iff (rst)
    image[1][6:0] == 7'h00 && image[2][6:0] == 7'h00
    && !image[0][`SIGN_BIT] && !image[3][`SIGN_BIT])
    else $error("input word stray bit set");

  code_place0_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && !conv.over[0] |=> image[0][14:7] == $past(conv.code[0]))
    else $error("input code misplaced");

  code_place1_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && !conv.over[1] |=> image[1][14:7] == $past(conv.code[1]))
    else $error("input code misplaced");

  code_place3_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && !conv.over[3] |=> image[3][14:7] == $past(conv.code[3]))
    else $error("input code misplaced");

  // Over-range, status and event words
  in_over_map_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_IN_OVER)][3:0] == $past(conv.over))
    else $error("input over-range flags wrong");

  out_over_map_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_OUT_STATUS)][1:0] == $past(conv.out_over))
    else $error("output over-range flags wrong");

  event_set_a: assert property (@(posedge clk) disable iff (rst)
    in_over_evt_s |=> evt_status[`EVT_IN_OVER_BIT])
    else $error("input over-range event lost");

  evt_clear_a: assert property (@(posedge clk) disable iff (rst)
    evt_clear0_s |=> !evt_status[`EVT_IN_OVER_BIT])
    else $error("event bit not cleared");

  out_over_evt_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid && (|conv.out_over) |=> evt_status[`EVT_OUT_OVER_BIT])
    else $error("output over-range event lost");

  bad_event_a: assert property (@(posedge clk) disable iff (rst)
    wr_bad0 || wr_bad1 |=> evt_status[`EVT_BAD_BIT])
    else $error("bad write event lost");

  bad_status_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_OUT_STATUS)][`BAD1_BIT:`BAD0_BIT] == $past(bad_flag))
    else $error("invalid-data flags not shown");

  hold_status_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_OUT_STATUS)][`HOLD1_BIT] == $past(holding[1])
    && image[word_slot(`IDX_OUT_STATUS)][`HOLD0_BIT] == $past(holding[0]))
    else $error("holding flags wrong");

  // Output words and converter drive
  drive_clamp_a: assert property (@(posedge clk) disable iff (rst)
    !program_mode && conv.out_over[1] |=> dac_code1 == `FULL_CODE)
    else $error("output over-range not clamped");

  good_store_a: assert property (@(posedge clk) disable iff (rst)
    good_write0_s |=> accepted[0] == $past(req.wdata[`VAL_MSB:`VAL_LSB]) && !bad_flag[0])
    else $error("valid output word not taken");

  good_store1_a: assert property (@(posedge clk) disable iff (rst)
    good_write1_s |=> accepted[1] == $past(req.wdata[`VAL_MSB:`VAL_LSB]) && !bad_flag[1])
    else $error("valid output word not taken");

  bad_keep1_a: assert property (@(posedge clk) disable iff (rst)
    wr_bad1 |=> accepted[1] == $past(accepted[1]) && bad_flag[1])
    else $error("bad output word accepted");

  zero_idle_a: assert property (@(posedge clk) disable iff (rst)
    program_mode && !holding[1] |=> dac_code1 == `CODE_RESET)
    else $error("idled output not zero");

  echo0_match_a: assert property (@(posedge clk) disable iff (rst)
    conv.valid |=> image[word_slot(`IDX_ECHO0)][14:7] == $past(dac_code0))
    else $error("echo differs from converted code");

  // Image as a whole
  image_steady_a: assert property (@(posedge clk) disable iff (rst)
    !conv.valid |=> image[0] == $past(image[0]) && image[7] == $past(image[7]))
    else $error("image changed without update");

  reset_clear_a: assert property (@(posedge clk) disable iff (rst)
    !seen_update |-> (image[0] | image[1] | image[2] | image[3]) == `WORD_RESET
    && (image[4] | image[5] | image[6] | image[7]) == `WORD_RESET)
    else $error("image not clear before first update");
endmodule : analog_io_input_image

/* testbench/host_model.sv */
// Host controller model: register port writes and reads.
// Assumes the image block samples req on clk rising edges.
`timescale 1ns/1ps
module host_model (
  input  wire logic               clk,
  input  wire logic [15:0]        rd_data,
  output aio_image_pkg::reg_req_s req
);
  import aio_image_pkg::*;
  // Port idle from time zero
  initial begin
    req = '0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  // Code in the value field only; stray bits would be refused
  task automatic put_code(input logic ch, input logic [7:0] c);
    wr({3'h4, ch}, {1'b0, c, 7'h00});
  endtask : put_code
endmodule : host_model

/* testbench/analog_io_input_image_bench.sv */
// Self-checking bench for the analog I/O input image.
// Assumes host_model drives the register port; converter pulses come from here.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module analog_io_input_image_bench;
  import aio_image_pkg::*;
  logic        clk;
  logic        rst;
  conv_in_s    conv;
  reg_req_s    req;
  logic [15:0] rd_data;
  logic [7:0]  dac_code0;
  logic [7:0]  dac_code1;
  logic        irq;
  int          n_mismatch;
  int          samples_checked;
  int          cycles;

  analog_io_input_image i_dut (.clk(clk), .rst(rst), .conv(conv), .req(req),
    .rd_data(rd_data), .dac_code0(dac_code0), .dac_code1(dac_code1), .irq(irq));
  host_model i_host (.clk(clk), .rd_data(rd_data), .req(req));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Converter update pulse; range levels stay afterwards
  task automatic send(input logic [31:0] c, input logic [3:0] ov, input logic [1:0] oo);
    @(posedge clk);
    conv <= '{valid: 1'b1, code: c, over: ov, out_over: oo};
    @(posedge clk);
    conv.valid <= 1'b0;
  endtask : send
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd(a, d);
    `CHK(d, e)
  endtask : rdc
  // Registered outputs need one more edge after a write lands
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rdc(4'(i), 16'h0000);
    `CHK(irq, 1'b0)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_inputs();
    send({8'h00, 8'h80, 8'hFF, 8'h01}, 4'h0, 2'h0);
    rdc(4'h0, 16'h0080);
    rdc(4'h1, 16'h7F80);
    rdc(4'h2, 16'h4000);
    rdc(4'h3, 16'h0000);
    rdc(4'h4, 16'h0000);
    $display("t_inputs done");
  endtask : t_inputs
  task automatic t_over();
    i_host.wr(4'hC, 16'h0001);
    send({8'h00, 8'h00, 8'h00, 8'h10}, 4'h5, 2'h0);
    rdc(4'h0, 16'h7F80);
    rdc(4'h1, 16'h0000);
    rdc(4'h4, 16'h0005);
    `CHK(irq, 1'b1)
    i_host.wr(4'hC, 16'h0000);
    settle();
    `CHK(irq, 1'b0)
    i_host.wr(4'hC, 16'h0001);
    rdc(4'hB, 16'h0001);
    i_host.wr(4'hB, 16'h0001);
    settle();
    `CHK(irq, 1'b0)
    send({8'h00, 8'h00, 8'h00, 8'h10}, 4'h0, 2'h0);
    rdc(4'h4, 16'h0000);
    rdc(4'h0, 16'h0800);
    $display("t_over done");
  endtask : t_over
  task automatic t_out();
    i_host.wr(4'hA, 16'h0001);
    i_host.put_code(1'b0, 8'h80);
    i_host.put_code(1'b1, 8'h01);
    send(32'h0, 4'h0, 2'h0);
    rdc(4'h6, 16'h4000);
    rdc(4'h7, 16'h0080);
    i_host.wr(4'h8, 16'h4001);
    i_host.wr(4'h9, 16'h8080);
    settle();
    `CHK(dac_code0, 8'h80)
    `CHK(dac_code1, 8'h01)
    send(32'h0, 4'h0, 2'h0);
    rdc(4'h5, 16'h000C);
    send(32'h0, 4'h0, 2'h3);
    settle();
    `CHK(dac_code0, 8'hFF)
    `CHK(dac_code1, 8'hFF)
    rdc(4'h5, 16'h000F);
    send(32'h0, 4'h0, 2'h0);
    rdc(4'h5, 16'h000C);
    $display("t_out done");
  endtask : t_out
  task automatic t_hold();
    i_host.wr(4'hA, 16'h0000);
    settle();
    `CHK(dac_code0, 8'h80)
    send(32'h0, 4'h0, 2'h0);
    rdc(4'h5, 16'h500C);
    i_host.wr(4'hA, 16'h0002);
    settle();
    `CHK(dac_code0, 8'h00)
    `CHK(dac_code1, 8'h01)
    send(32'h0, 4'h0, 2'h0);
    rdc(4'h5, 16'h100C);
    i_host.wr(4'hA, 16'h0004);
    settle();
    `CHK(dac_code1, 8'h00)
    $display("t_hold done");
  endtask : t_hold
  task automatic t_ro();
    i_host.wr(4'h0, 16'hFFFF);
    i_host.wr(4'h7, 16'hFFFF);
    rdc(4'h0, 16'h0000);
    rdc(4'h7, 16'h0080);
    rdc(4'hE, 16'h0000);
    rdc(4'hB, 16'h0006);
    $display("t_ro done");
  endtask : t_ro

  // Reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    conv = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_inputs();
    t_over();
    t_out();
    t_hold();
    t_ro();
    // Second reset mid-run; the image must come back clear
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    results();
  end
endmodule : analog_io_input_image_bench
